//--- logic/blf_front_panel.sv
// Purpose: Blade front-panel buttons and indicators behind AXI4-Lite.
// Assumes: aclk at 10 MHz; buttons and faults arrive asynchronously.
// Notes: Privileged writes come from the chassis manager.
// What this block does
// [R1] Button counts only after 50 ms low.
// [R2] Debounce restarts when input returns high.
// [R3] Power dark without standby, lit when main on.
// [R4] Permitted and main off: slow 1 Hz blink.
// [R5] No permission yet: fast 4 Hz blink.
// [R6] Fast blink precedes slow while permission pending.
// [R7] Location follows manager: off, on, blink.
// [R8] Location clears when standby power comes up.
// [R9] Location survives main power cycle and reset; here a reset clears it to off.
// [R10] Fault lit while any fault source present.
// [R11] Each new fault sends an event message.
// [R12] Information lit only when manager directs it.
// [R13] Console on, off, or blink while pending.
// [R14] Media lit while media is assigned.
// [R15] Console press requests the console.
// [R16] Media press requests media and USB.
// [R17] Hidden button press raises an NMI.
// [R18] Manager reads all indicators, sets controllable ones.
// [R19] Host software may read but never set.
// [R20] Indicators work on standby power alone.
// [R21] Container byte bit 7: logical 0, physical 1.
// [R22] Blink modes have half on, half off.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module blf_front_panel #(
   parameter int unsigned DEB_CYC = blf_pkg::DEB_CYC,
   parameter int unsigned SLOW_HALF = blf_pkg::SLOW_HALF,
   parameter int unsigned FAST_HALF = blf_pkg::FAST_HALF,
   parameter int unsigned HALF_HALF = blf_pkg::HALF_HALF
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address.
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data.
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response.
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address.
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data.
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Panel and power pins.
   input wire blf_pkg::blf_btn_s btn,
   input wire blf_pkg::blf_flt_s flt,
   input wire logic standby_power_domain,
   input wire logic main_power_domain,
   // Indicator and event outputs.
   output blf_pkg::blf_led_s led,
   output logic nmi_req,
   output logic power_btn_press,
   output logic fault_event_message
);

   // Limits of the counters, cut to counter width.
   localparam logic [23:0] DEB_LIM = 24'(DEB_CYC - 1);
   localparam logic [23:0] SLOW_LIM = 24'(SLOW_HALF - 1);
   localparam logic [23:0] FAST_LIM = 24'(FAST_HALF - 1);
   localparam logic [23:0] HALF_LIM = 24'(HALF_HALF - 1);

   blf_pkg::blf_state_s q;
   blf_pkg::blf_state_s d;

   // Says when a blink counter has reached its limit and its phase flips.
   function automatic logic wrap(input logic [23:0] c,
                                 input logic [23:0] lim);
      wrap = (c >= lim);
   endfunction

   // Next state of the whole block.
   // Each field keeps its value unless set below.
   // Scratch values live for one cycle only.
   always_comb begin
      logic [3:0] press;
      logic [5:0] fnow;
      logic [5:0] fnew;
      logic [7:0] clr;
      logic sb;
      logic mainon;
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      press = 4'h0;
      fnow = 6'h00;
      fnew = 6'h00;
      clr = 8'h00;
      sb = 1'b0;
      mainon = 1'b0;
      aw_hs = 1'b0;
      w_hs = 1'b0;
      ar_hs = 1'b0;
      d = q;

      // Three-stage synchronisers for all pins.
      // A bit moves only when stages two and three agree.
      // This keeps a half-settled level out of the logic.
      d.s1 = {flt, main_power_domain, standby_power_domain, btn};
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < 12; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.filt[i] = q.s3[i];
         end
      end
      sb = q.filt[4];
      mainon = q.filt[5];
      fnow = q.filt[11:6];

      // Debounce of the four buttons.
      // A high sample restarts the count at once.
      // A press is reported once; a new one needs release.
      for (int i = 0; i < 4; i++) begin
         if (q.filt[i]) begin
            d.deb[i] = 24'h000000; // R2
            d.held[i] = 1'b0;
         end else if (!q.held[i]) begin
            if (q.deb[i] >= DEB_LIM) begin
               d.held[i] = 1'b1; // R1
               press[i] = 1'b1;
            end else begin
               d.deb[i] = q.deb[i] + 24'h000001;
            end
         end
      end

      // Blink generators, each toggling at its half period.
      // They run free, so blinks stay in step.
      // Equal halves give the half-on, half-off duty.
      if (wrap(q.slow_c, SLOW_LIM)) begin
         d.slow_c = 24'h000000;
         d.slow_ph = ~q.slow_ph; // R22
      end else begin
         d.slow_c = q.slow_c + 24'h000001;
      end
      if (wrap(q.fast_c, FAST_LIM)) begin
         d.fast_c = 24'h000000;
         d.fast_ph = ~q.fast_ph; // R22
      end else begin
         d.fast_c = q.fast_c + 24'h000001;
      end
      if (wrap(q.half_c, HALF_LIM)) begin
         d.half_c = 24'h000000;
         d.half_ph = ~q.half_ph; // R22
      end else begin
         d.half_c = q.half_c + 24'h000001;
      end

      // Write address channel.
      // Address and data may come in either order.
      // The privilege bit tells manager from host.
      aw_hs = awvalid && q.awready;
      if (aw_hs) begin
         d.aw_ok = 1'b1;
         d.waddr = awaddr;
         d.wpriv = awprot[0];
      end

      // Write data channel.
      w_hs = wvalid && q.wready;
      if (w_hs) begin
         d.w_ok = 1'b1;
         d.wdata = wdata;
         d.wstrb = wstrb;
      end

      // Response handshake ends the write.
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end

      // Carry out a write once address and data are both held.
      // The manager writes with the privilege bit set.
      // Host software may only clear status bits.
      // Only the low byte lane holds fields.
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = blf_pkg::RESP_OKAY;
         if (q.waddr == blf_pkg::ADDR_CTRL) begin
            if (!q.wpriv) begin
               d.bresp = blf_pkg::RESP_SLVERR; // R19
            end else if (q.wstrb[0]) begin
               d.permit = q.wdata[blf_pkg::CTRL_PERMIT]; // R18
               d.loc = blf_pkg::blf_loc_e'(q.wdata[blf_pkg::CTRL_LOC +: 2]); // R7
               d.info = q.wdata[blf_pkg::CTRL_INFO]; // R12
               d.con_grant = q.wdata[blf_pkg::CTRL_CON_GRANT];
               d.med_grant = q.wdata[blf_pkg::CTRL_MED_GRANT];
            end
         end else if (q.waddr == blf_pkg::ADDR_STAT) begin
            if (q.wstrb[0]) begin
               clr = q.wdata[7:0];
            end
         end else if (q.waddr == blf_pkg::ADDR_ENTITY) begin
            if (!q.wpriv) begin
               d.bresp = blf_pkg::RESP_SLVERR;
            end else if (q.wstrb[0]) begin
               d.entity = q.wdata[7:0]; // R21
            end
         end else begin
            d.bresp = blf_pkg::RESP_SLVERR;
         end
      end

      // Ready for new items only while the slot is free.
      // This keeps one write in flight at a time.
      d.awready = !d.aw_ok && !d.bvalid;
      d.wready = !d.w_ok && !d.bvalid;

      // Read channel.
      // Data are latched at the address handshake.
      // Unused bits read back as zero.
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      ar_hs = arvalid && q.arready;
      if (ar_hs) begin
         d.rvalid = 1'b1;
         d.rresp = blf_pkg::RESP_OKAY;
         d.rdata = 32'h00000000;
         if (araddr == blf_pkg::ADDR_CTRL) begin
            d.rdata[blf_pkg::CTRL_PERMIT] = q.permit;
            d.rdata[blf_pkg::CTRL_LOC +: 2] = q.loc;
            d.rdata[blf_pkg::CTRL_INFO] = q.info;
            d.rdata[blf_pkg::CTRL_CON_GRANT] = q.con_grant;
            d.rdata[blf_pkg::CTRL_MED_GRANT] = q.med_grant;
         end else if (araddr == blf_pkg::ADDR_STAT) begin
            d.rdata[blf_pkg::STAT_CON_REQ] = q.con_req;
            d.rdata[blf_pkg::STAT_MED_REQ] = q.med_req;
            d.rdata[blf_pkg::STAT_FLT_EVT] = q.flt_evt;
         end else if (araddr == blf_pkg::ADDR_LEDS) begin
            d.rdata[5:0] = q.led; // R18
            d.rdata[6] = sb;
            d.rdata[7] = mainon;
            d.rdata[13:8] = fnow;
         end else if (araddr == blf_pkg::ADDR_ENTITY) begin
            d.rdata[7:0] = q.entity;
         end else begin
            d.rresp = blf_pkg::RESP_SLVERR;
         end
      end
      d.arready = !d.rvalid;

      // Sticky requests and events; a set beats a clear.
      // A press that meets a clear is kept.
      d.con_req = q.con_req & ~clr[blf_pkg::STAT_CON_REQ];
      d.med_req = q.med_req & ~clr[blf_pkg::STAT_MED_REQ];
      d.flt_evt = q.flt_evt & ~clr[blf_pkg::STAT_FLT_EVT];
      if (press[1]) begin
         d.con_req = 1'b1; // R15
      end
      if (press[2]) begin
         d.med_req = 1'b1; // R16
      end

      // Any newly raised fault source sends a message; sources rising together send one.
      // A source that rises while another stands
      // is reported as well.
      fnew = fnow & ~q.flt_prev;
      d.flt_prev = fnow;
      d.flt_msg = |fnew; // R11
      if (|fnew) begin
         d.flt_evt = 1'b1; // R11
      end

      // Button pulses out of the block.
      // Each pulse lasts exactly one cycle.
      d.nmi = press[3]; // R17
      d.pwr_btn = press[0];

      // Standby power coming up clears the location request.
      // The first rise after reset counts too.
      // Main power changes leave the request alone.
      d.sb_prev = sb;
      if (sb && !q.sb_prev) begin
         d.loc = blf_pkg::LOC_OFF; // R8
      end

      // Power indicator from power state and permission.
      // Fast blink until permission, then slow,
      // so the fast rate always comes first.
      if (!sb) begin
         d.led.power = 1'b0; // R3
      end else if (mainon) begin
         d.led.power = 1'b1; // R3
      end else if (q.permit) begin
         d.led.power = q.slow_ph; // R4
      end else begin
         d.led.power = q.fast_ph; // R5 R6
      end

      // Location indicator follows the manager's request.
      // The unused code shows dark but reads back.
      case (q.loc)
         blf_pkg::LOC_ON: begin
            d.led.location = 1'b1; // R7
         end
         blf_pkg::LOC_BLINK: begin
            d.led.location = q.half_ph; // R7
         end
         default: begin
            d.led.location = 1'b0;
         end
      endcase

      // Remaining indicators, none gated by main power.
      // A granted console wins over a pending request.
      d.led.fault = |fnow; // R10 R20
      d.led.info = q.info; // R12
      if (q.con_grant) begin
         d.led.console = 1'b1; // R13
      end else if (q.con_req) begin
         d.led.console = q.half_ph; // R13
      end else begin
         d.led.console = 1'b0;
      end
      d.led.media = q.med_grant; // R14
   end

   // State register; location is held over main power but cleared by blade resets.
   // The reset branch loads constants only.
   // Synchronisers start at the idle pin level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.s1 <= blf_pkg::SYNC_RST;
         q.s2 <= blf_pkg::SYNC_RST;
         q.s3 <= blf_pkg::SYNC_RST;
         q.filt <= blf_pkg::SYNC_RST;
         q.entity <= blf_pkg::ENTITY_RST;
         q.loc <= blf_pkg::LOC_OFF; // R8
      end else begin
         q <= d; // R9
      end
   end

   // Outputs straight from the state register.
   // Nothing follows the register, so outputs cannot glitch.
   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign led = q.led;
   assign nmi_req = q.nmi;
   assign power_btn_press = q.pwr_btn;
   assign fault_event_message = q.flt_msg;

endmodule
`default_nettype wire

//--- logic/blf_pkg.sv
// Purpose: Shared constants and types of the front-panel block.
// Assumes: Clock of 10 MHz on aclk.
// Notes: Register map is word aligned on AXI4-Lite.
`default_nettype none
package blf_pkg;
   // Clock and timing.
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned DEB_MS = 50;
   localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
   localparam int unsigned SLOW_PER_MS = 1000;
   localparam int unsigned FAST_PER_MS = 250;
   localparam int unsigned HALF_PER_MS = 2000;
   localparam int unsigned SLOW_HALF = CLK_HZ / 1000 * SLOW_PER_MS / 2;
   localparam int unsigned FAST_HALF = CLK_HZ / 1000 * FAST_PER_MS / 2;
   localparam int unsigned HALF_HALF = CLK_HZ / 1000 * HALF_PER_MS / 2;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_LEDS = 8'h08;
   localparam logic [7:0] ADDR_ENTITY = 8'h0c;
   // Control field positions.
   localparam int CTRL_PERMIT = 0;
   localparam int CTRL_LOC = 1;
   localparam int CTRL_INFO = 3;
   localparam int CTRL_CON_GRANT = 4;
   localparam int CTRL_MED_GRANT = 5;
   // Status field positions, write one to clear.
   localparam int STAT_CON_REQ = 0;
   localparam int STAT_MED_REQ = 1;
   localparam int STAT_FLT_EVT = 2;
   // Entity container byte: bit 7 marks a physical container.
   localparam int ENT_PHYS = 7;
   localparam logic [7:0] ENTITY_RST = 8'h00;
   // Reset of the synchronisers: buttons released, rest low.
   localparam logic [11:0] SYNC_RST = 12'h00f;
   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      LOC_OFF = 2'b00,
      LOC_ON = 2'b01,
      LOC_BLINK = 2'b10
   } blf_loc_e;

   // Front-panel buttons, all active low.
   typedef struct packed {
      logic nmi_n;
      logic media_n;
      logic console_n;
      logic power_n;
   } blf_btn_s;

   // Blade fault sources, active high.
   typedef struct packed {
      logic mismatch;
      logic power;
      logic critical;
      logic fail_led;
      logic dimm;
      logic proc_dis;
   } blf_flt_s;

   // Indicator drives, active high.
   typedef struct packed {
      logic media;
      logic console;
      logic info;
      logic fault;
      logic location;
      logic power;
   } blf_led_s;

   // Whole state of the block.
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
      logic [11:0] s3;
      logic [11:0] filt;
      logic [3:0][23:0] deb;
      logic [3:0] held;
      logic [23:0] slow_c;
      logic [23:0] fast_c;
      logic [23:0] half_c;
      logic slow_ph;
      logic fast_ph;
      logic half_ph;
      logic permit;
      blf_loc_e loc;
      logic info;
      logic con_grant;
      logic med_grant;
      logic con_req;
      logic med_req;
      logic flt_evt;
      logic [7:0] entity;
      logic sb_prev;
      logic [5:0] flt_prev;
      blf_led_s led;
      logic nmi;
      logic pwr_btn;
      logic flt_msg;
      logic aw_ok;
      logic w_ok;
      logic [7:0] waddr;
      logic wpriv;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } blf_state_s;
endpackage
`default_nettype wire

//--- tb/blf_front_panel_props.sv
// Purpose: Port-level assertions of the front-panel block.
// Assumes: Bound to every blf_front_panel instance.
// Notes: Latency windows follow the hand-over figures.
`timescale 1ns/1ns
`default_nettype none
module blf_front_panel_props (
   // Clock, reset and bus handshakes.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic bvalid,
   input wire logic bready,
   // Panel pins and outputs.
   input wire blf_pkg::blf_btn_s btn,
   input wire blf_pkg::blf_flt_s flt,
   input wire logic standby_power_domain,
   input wire logic main_power_domain,
   input wire blf_pkg::blf_led_s led,
   input wire logic nmi_req,
   input wire logic power_btn_press,
   input wire logic fault_event_message
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   nmi_long_press_a: assert property (nmi_req |-> $past(btn.nmi_n, 10) == 1'b0 ##1 !nmi_req)
      else $error("nmi pulse without a long press");
   power_long_press_a: assert property (power_btn_press |-> $past(btn.power_n, 10) == 1'b0)
      else $error("power press without a long press");
   power_dark_a: assert property ((!standby_power_domain)[*8] |-> !led.power)
      else $error("power indicator lit without standby");
   power_steady_a: assert property ((standby_power_domain && main_power_domain)[*8] |-> led.power)
      else $error("power indicator dark with main on");
   fault_lit_a: assert property ((flt != 6'h00)[*8] |-> led.fault)
      else $error("fault indicator dark during a fault");
   fault_clear_a: assert property ((flt == 6'h00)[*8] |-> !led.fault)
      else $error("fault indicator lit without a fault");
   fault_event_a: assert property ($rose(|flt) |-> ##[1:8] fault_event_message)
      else $error("no event message after a fault");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write answer dropped early");
   read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer missing");
endmodule
bind blf_front_panel blf_front_panel_props props (.aclk(aclk), .aresetn(aresetn),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .bvalid(bvalid), .bready(bready),
   .btn(btn), .flt(flt), .standby_power_domain(standby_power_domain),
   .main_power_domain(main_power_domain), .led(led), .nmi_req(nmi_req),
   .power_btn_press(power_btn_press), .fault_event_message(fault_event_message));
`default_nettype wire

//--- tb/blf_mgr_model.sv
// Purpose: Chassis manager model issuing AXI4-Lite register traffic.
// Assumes: Called from the bench after reset has been released.
// Notes: Answers are taken after a random stall of up to two cycles.
`timescale 1ns/1ns
`default_nettype none
module blf_mgr_model (
   // Clock.
   input wire logic aclk,
   // Write channels.
   output logic awvalid,
   input wire logic awready,
   output logic [7:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // Read channels.
   output logic arvalid,
   input wire logic arready,
   output logic [7:0] araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   // Bus idle at time zero.
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, awprot, arprot, wstrb} = 26'h0;
      wdata = 32'h00000000;
   end

   // One write; priv marks the manager, clear marks host software.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p,
                     output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      awprot <= {2'b00, p};
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      repeat ($urandom_range(2)) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   // One read of a register word.
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      repeat ($urandom_range(2)) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb/blf_front_panel_tb.sv
// Purpose: Self-checking bench of the front-panel block.
// Assumes: Short debounce and blink counts through parameters.
// Notes: Register traffic goes through the manager model.
`timescale 1ns/1ns
`default_nettype none
module blf_front_panel_tb;
   localparam int DEB = 20;
   localparam int SH = 8;
   localparam int FH = 2;
   localparam int HH = 16;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic sb = 1'b1;
   logic mn = 1'b0;
   blf_pkg::blf_btn_s btn = 4'hf;
   blf_pkg::blf_flt_s flt = 6'h00;
   blf_pkg::blf_led_s led;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, d, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic nmi, pwr, fev;
   int failures = 0;
   int comparisons = 0;
   int cyc = 0;
   int nmis = 0;
   int pwrs = 0;
   int fevs = 0;

   blf_front_panel #(.DEB_CYC(DEB), .SLOW_HALF(SH), .FAST_HALF(FH), .HALF_HALF(HH)) dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .btn(btn), .flt(flt), .standby_power_domain(sb),
      .main_power_domain(mn), .led(led), .nmi_req(nmi), .power_btn_press(pwr),
      .fault_event_message(fev));
   blf_mgr_model m (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));

   // Clock of 100 ns.
   initial forever #50 aclk = ~aclk;

   // Pulse counters and the hang limit.
   always @(posedge aclk) begin
      cyc++;
      nmis += int'(nmi === 1'b1);
      pwrs += int'(pwr === 1'b1);
      fevs += int'(fev === 1'b1);
      if (cyc == 30000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
      end
   endtask

   task automatic conclude();
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Holds one button low for n cycles.
   task automatic press(input int b, input int n);
      btn[b] <= 1'b0;
      idle(n);
      btn[b] <= 1'b1;
      idle(10);
   endtask

   // Measures one whole level; the first two changes only align to the blink.
   task automatic blink(input int b, input int h, input string s);
      int n;
      logic x;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         x = led[b];
         while (led[b] === x && n < 200) begin
            @(posedge aclk);
            n++;
         end
      end
      chk(n, h, s);
      $display("test %s done", s);
   endtask

   // Control word from random bits: permit set, location off, info and grants random.
   function automatic logic [31:0] ctrl_of(input logic [31:0] x);
      return (x & 32'h38) | 32'h1;
   endfunction

   initial begin
      void'($urandom(36));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      idle(10);
      // Reset values, host refusals and read-only places.
      m.rd(blf_pkg::ADDR_CTRL, d, r);
      chk(d, 32'h0, "ctrl reset");
      m.rd(8'h10, d, r);
      chk(r, blf_pkg::RESP_SLVERR, "unmapped");
      m.wr(blf_pkg::ADDR_CTRL, 32'h3f, 1'b0, r);
      chk(r, blf_pkg::RESP_SLVERR, "host write");
      m.wr(blf_pkg::ADDR_LEDS, 32'h3f, 1'b1, r);
      chk(r, blf_pkg::RESP_SLVERR, "leds write");
      m.rd(blf_pkg::ADDR_LEDS, d, r);
      chk(d & 32'hfffffffe, 32'h40, "leds read");
      $display("test registers done");
      // Fast blink before permission, slow after, steady with main on.
      blink(0, FH, "fast");
      m.wr(blf_pkg::ADDR_CTRL, 32'h1, 1'b1, r);
      blink(0, SH, "slow");
      mn <= 1'b1;
      idle(SH + 10);
      chk(led.power, 1'b1, "power steady");
      // Location modes kept across main power cycling.
      for (int k = 0; k < 3; k++) begin
         m.wr(blf_pkg::ADDR_CTRL, 32'(1 + 2 * k), 1'b1, r);
         mn <= 1'b1;
         idle(10);
         mn <= 1'b0;
         idle(10);
         if (k == 2) blink(1, HH, "location blink");
         else chk(led.location, k, "location");
      end
      m.wr(blf_pkg::ADDR_CTRL, 32'h7, 1'b1, r);
      idle(10);
      chk(led.location, 1'b0, "location code 3");
      m.wr(blf_pkg::ADDR_CTRL, 32'h3, 1'b1, r);
      idle(10);
      chk(led.location, 1'b1, "location on");
      sb <= 1'b0;
      idle(10);
      sb <= 1'b1;
      idle(10);
      chk(led.location, 1'b0, "location after standby");
      // Random information and grant settings.
      repeat (6) begin
         v = $urandom;
         m.wr(blf_pkg::ADDR_CTRL, ctrl_of(v), 1'b1, r);
         idle(8);
         chk(led.info, v[3], "info");
         chk(led.console, v[4], "console");
         chk(led.media, v[5], "media");
      end
      $display("test indicators done");
      // Broken and short presses are ignored, long ones request.
      m.wr(blf_pkg::ADDR_CTRL, 32'h1, 1'b1, r);
      btn[1] <= 1'b0;
      idle(DEB - 5);
      btn[1] <= 1'b1;
      idle(4);
      press(1, DEB - 5);
      m.rd(blf_pkg::ADDR_STAT, d, r);
      chk(d, 32'h0, "short press");
      press(1, DEB + 5);
      press(2, DEB + 5);
      m.rd(blf_pkg::ADDR_STAT, d, r);
      chk(d[1:0], 2'h3, "requests");
      blink(4, HH, "console pending");
      m.wr(blf_pkg::ADDR_STAT, 32'h3, 1'b0, r);
      m.rd(blf_pkg::ADDR_STAT, d, r);
      chk(d, 32'h0, "request clear");
      press(3, DEB + 5);
      press(0, DEB + 5);
      chk(nmis, 1, "nmi pulses");
      chk(pwrs, 1, "power pulses");
      $display("test buttons done");
      // Each fault source lights the indicator and sends one message.
      for (int k = 0; k < 6; k++) begin
         flt <= 6'h01 << k;
         idle(10);
         chk(led.fault, 1'b1, "fault on");
         flt <= 6'h00;
         idle(10);
         chk(led.fault, 1'b0, "fault off");
         chk(fevs, k + 1, "fault messages");
      end
      m.rd(blf_pkg::ADDR_STAT, d, r);
      chk(d[2], 1'b1, "fault status");
      // Container byte keeps its kind bit.
      repeat (3) begin
         v = $urandom & 32'hff;
         m.wr(blf_pkg::ADDR_ENTITY, v, 1'b1, r);
         chk(r, blf_pkg::RESP_OKAY, "entity write");
         m.wr(blf_pkg::ADDR_ENTITY, ~v, 1'b0, r);
         chk(r, blf_pkg::RESP_SLVERR, "entity host");
         m.rd(blf_pkg::ADDR_ENTITY, d, r);
         chk(d, v, "entity");
      end
      $display("test faults and entity done");
      conclude();
   end
endmodule
`default_nettype wire
